// *** shared/ilo_pkg.sv ***
// Constants and types shared by the indexed literal offset decode and execute block.
package ilo_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Data space and register map (byte addresses on the APB bus).
  localparam int unsigned   ADDR_W     = 12;
  localparam logic [7:0]    OFF_CTRL   = 8'h00;
  localparam logic [7:0]    OFF_INSTR  = 8'h04;
  localparam logic [7:0]    OFF_STATUS = 8'h08;
  localparam logic [7:0]    OFF_ACC    = 8'h0c;
  localparam logic [7:0]    OFF_PTR2   = 8'h10;
  localparam logic [7:0]    OFF_BANK   = 8'h14;
  localparam logic [7:0]    OFF_EADDR  = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and values after reset.
  localparam int unsigned   CTRL_EXT_BIT   = 0;
  localparam int unsigned   FLAG_C         = 0;
  localparam int unsigned   FLAG_DC        = 1;
  localparam int unsigned   FLAG_Z         = 2;
  localparam int unsigned   FLAG_OV        = 3;
  localparam int unsigned   FLAG_N         = 4;
  localparam int unsigned   STAT_BUSY      = 8;
  localparam int unsigned   STAT_ILLEGAL   = 9;
  localparam logic          EXT_RST        = 1'b0;
  localparam logic [7:0]    ACC_RST        = 8'h00;
  localparam logic [11:0]   PTR2_RST       = 12'h000;
  localparam logic [3:0]    BANK_RST       = 4'h0;
  localparam logic [4:0]    FLAGS_RST      = 5'h00;
  localparam logic [15:0]   INSTR_RST      = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Opcode patterns, address limits and constants of the operations.
  localparam logic [5:0]    OPC_ADD        = 6'h09;
  localparam logic [3:0]    OPC_BSET       = 4'h8;
  localparam logic [6:0]    OPC_SET_ALL_INDEXED       = 7'h34;
  localparam logic [7:0]    INDEX_LIMIT    = 8'h5f;
  localparam logic [7:0]    ACCESS_LOW_TOP = 8'h7f;
  localparam logic [3:0]    ACCESS_HI_BANK = 4'hf;
  localparam logic [7:0]    ALL_ONES       = 8'hff;

  typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_BSET, OP_SET_ALL_INDEXED} op_e;
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

endpackage

// *** logic/ea_decode.sv ***
// Opcode classification and effective address formation for byte and bit operations.
`timescale 1ns/1ps
`default_nettype none

module ea_decode (
  // Instruction and addressing state
  input  wire logic [15:0]             instr,
  input  wire logic                    ext_en,
  input  wire logic [11:0]             ptr2,
  input  wire logic [3:0]              bank,
  // Decoded result
  output ilo_pkg::op_e                 op,
  output logic      [11:0]             ea,
  output logic                         indexed,
  output logic                         dest_mem,
  output logic      [2:0]              bit_sel
);

  // Only the three supported patterns are recognised; anything else is no operation.
  function automatic ilo_pkg::op_e classify(input logic [15:0] w);
    if (w[15:10] == ilo_pkg::OPC_ADD)
      return ilo_pkg::OP_ADD;
    else if (w[15:12] == ilo_pkg::OPC_BSET)
      return ilo_pkg::OP_BSET;
    else if (w[15:9] == ilo_pkg::OPC_SET_ALL_INDEXED)
      return ilo_pkg::OP_SET_ALL_INDEXED;
    else
      return ilo_pkg::OP_NONE;
  endfunction

  logic [7:0] f_arg;
  logic       acc_bit;

  // Field extraction; the destination bit keeps its usual meaning in both modes.
  always_comb
  begin
    f_arg    = instr[7:0];
    acc_bit  = instr[8];
    op       = classify(instr);
    dest_mem = instr[9];
    bit_sel  = instr[11:9];
  end

  // Indexed only with the extended set on, the access bit clear and a low argument.
  always_comb
  begin
    indexed = ext_en && !acc_bit && (f_arg <= ilo_pkg::INDEX_LIMIT);
    if (indexed)
      ea = ptr2 + {4'h0, f_arg};
    else if (acc_bit)
      ea = {bank, f_arg};
    else if (f_arg <= ilo_pkg::ACCESS_LOW_TOP)
      ea = {4'h0, f_arg};
    else
      ea = {ilo_pkg::ACCESS_HI_BANK, f_arg};
  end

endmodule

`default_nettype wire

// *** logic/ilo_core.sv ***
// Four-phase executor of indexed byte and bit operations with an APB register file.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - With extension on and access bit clear, an argument up to 5Fh is an offset from pointer two.
// - In indexed operation the access bit counts as clear whatever the address.
// - The destination bit still picks accumulator or memory as the result target.
// - The indexed add sums the accumulator and the byte at pointer two plus the 8-bit offset.
// - Destination bit zero writes the sum to the accumulator, one writes it back to memory.
// - The indexed add updates negative, overflow, carry, digit carry and zero flags.
// - The indexed bit set sets the bit picked by a 3-bit field in the addressed byte.
// - The indexed set writes all ones to the addressed byte and leaves the flags alone.
// - Extension and indexing work only when the enable bit is one; it resets to zero.
// - Without extension, access bit zero picks the access bank and one the selected bank.
module ilo_core #(
  parameter int ADDR_W = ilo_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Data memory port
  output logic      [ADDR_W-1:0]       mem_addr,
  output logic                         mem_re,
  output logic                         mem_we,
  output logic      [7:0]              mem_wdata,
  input  wire logic [7:0]              mem_rdata,
  // Execution state
  output logic                         busy,
  output logic                         indexed_access
);

  // The bank register and the pointer width fix the data space at 4096 bytes.
  if (ADDR_W != 12)
  begin : g_bad_width
    $error("ADDR_W must be 12");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic rst_sync1_reg;
  logic rst_sync2_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State and decode.
  ilo_pkg::phase_e   phase_reg;
  ilo_pkg::op_e      op_reg;
  ilo_pkg::op_e      dec_op;
  logic              ext_reg;
  logic [15:0]       instr_reg;
  logic [7:0]        acc_reg;
  logic [11:0]       ptr2_reg;
  logic [3:0]        bank_reg;
  logic [4:0]        flags_reg;
  logic              illegal_reg;
  logic              dest_reg;
  logic [2:0]        bit_reg;
  logic [7:0]        acc_a_reg;
  logic [7:0]        operand_reg;
  logic [11:0]       dec_ea;
  logic              dec_indexed;
  logic              dec_dest;
  logic [2:0]        dec_bit;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic              mem_re_reg;
  logic              mem_we_reg;
  logic [7:0]        mem_wdata_reg;
  logic              indexed_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       rd_word;
  logic              addr_err;
  logic [7:0]        result;
  logic [4:0]        add_flags;
  logic              apb_setup;
  logic              apb_done;
  logic              wr_ok;
  logic              start;

  ea_decode u_decode (
    .instr    (instr_reg),
    .ext_en   (ext_reg),
    .ptr2     (ptr2_reg),
    .bank     (bank_reg),
    .op       (dec_op),
    .ea       (dec_ea),
    .indexed  (dec_indexed),
    .dest_mem (dec_dest),
    .bit_sel  (dec_bit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB: one wait-free access phase; refused writes answer with an error.
  assign apb_setup = psel && !penable;
  assign apb_done  = psel && penable && pready_reg;
  assign wr_ok     = apb_done && pwrite && !pslverr_reg;
  assign start     = wr_ok && (paddr == ilo_pkg::OFF_INSTR);

  // Read mux and refusal: unmapped addresses, and writes to live state while busy.
  always_comb
  begin
    rd_word  = 32'h0;
    addr_err = 1'b0;
    case (paddr)
      ilo_pkg::OFF_CTRL:   rd_word[ilo_pkg::CTRL_EXT_BIT] = ext_reg;
      ilo_pkg::OFF_INSTR:  rd_word[15:0] = instr_reg;
      ilo_pkg::OFF_STATUS:
      begin
        rd_word[4:0]                  = flags_reg;
        rd_word[ilo_pkg::STAT_BUSY]    = (phase_reg != ilo_pkg::PH_IDLE);
        rd_word[ilo_pkg::STAT_ILLEGAL] = illegal_reg;
      end
      ilo_pkg::OFF_ACC:    rd_word[7:0] = acc_reg;
      ilo_pkg::OFF_PTR2:   rd_word[11:0] = ptr2_reg;
      ilo_pkg::OFF_BANK:   rd_word[3:0] = bank_reg;
      ilo_pkg::OFF_EADDR:  rd_word[ADDR_W-1:0] = mem_addr_reg;
      default:             addr_err = 1'b1;
    endcase
    if (pwrite && (phase_reg != ilo_pkg::PH_IDLE) && (paddr != ilo_pkg::OFF_STATUS)
        && (paddr != ilo_pkg::OFF_EADDR))
      addr_err = 1'b1;
  end

  // Answer registers are loaded in the setup cycle so the access phase ends at once.
  always_ff @(posedge mclk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && addr_err;
      if (apb_setup && !pwrite)
        prdata_reg <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation results, taken from the memory byte sampled at the end of Q3.
  always_comb
  begin
    logic [8:0] sum9;
    logic [4:0] low5;
    sum9      = {1'b0, acc_a_reg} + {1'b0, mem_rdata};
    low5      = {1'b0, acc_a_reg[3:0]} + {1'b0, mem_rdata[3:0]};
    add_flags = 5'h0;
    add_flags[ilo_pkg::FLAG_C]  = sum9[8];
    add_flags[ilo_pkg::FLAG_DC] = low5[4];
    add_flags[ilo_pkg::FLAG_Z]  = (sum9[7:0] == 8'h00);
    add_flags[ilo_pkg::FLAG_N]  = sum9[7];
    add_flags[ilo_pkg::FLAG_OV] = (acc_a_reg[7] == mem_rdata[7]) && (sum9[7] != acc_a_reg[7]);
    case (op_reg)
      ilo_pkg::OP_ADD:  result = sum9[7:0];
      ilo_pkg::OP_BSET: result = mem_rdata | (8'h01 << bit_reg);
      ilo_pkg::OP_SET_ALL_INDEXED: result = ilo_pkg::ALL_ONES;
      default:          result = mem_rdata;
    endcase
  end

  // Software-visible registers; the add writes flags, and the accumulator when the destination bit is zero, at the end of Q3.
  always_ff @(posedge mclk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      ext_reg   <= ilo_pkg::EXT_RST;
      instr_reg <= ilo_pkg::INSTR_RST;
      acc_reg   <= ilo_pkg::ACC_RST;
      ptr2_reg  <= ilo_pkg::PTR2_RST;
      bank_reg  <= ilo_pkg::BANK_RST;
      flags_reg <= ilo_pkg::FLAGS_RST;
    end
    else
    begin
      if (wr_ok)
      begin
        case (paddr)
          ilo_pkg::OFF_CTRL:  ext_reg   <= pwdata[ilo_pkg::CTRL_EXT_BIT];
          ilo_pkg::OFF_INSTR: instr_reg <= pwdata[15:0];
          ilo_pkg::OFF_ACC:   acc_reg   <= pwdata[7:0];
          ilo_pkg::OFF_PTR2:  ptr2_reg  <= pwdata[11:0];
          ilo_pkg::OFF_BANK:  bank_reg  <= pwdata[3:0];
          default:            ;
        endcase
      end
      if ((phase_reg == ilo_pkg::PH_Q3) && (op_reg == ilo_pkg::OP_ADD))
      begin
        flags_reg <= add_flags;
        if (!dest_reg)
          acc_reg <= result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Four-phase sequencer: decode, read, process, write; one instruction per start.
  always_ff @(posedge mclk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      phase_reg     <= ilo_pkg::PH_IDLE;
      op_reg        <= ilo_pkg::OP_NONE;
      illegal_reg   <= 1'b0;
      dest_reg      <= 1'b0;
      bit_reg       <= 3'h0;
      acc_a_reg     <= 8'h00;
      operand_reg   <= 8'h00;
      mem_addr_reg  <= '0;
      mem_re_reg    <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
      indexed_reg   <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        ilo_pkg::PH_IDLE:
          if (start)
            phase_reg <= ilo_pkg::PH_Q1;
        ilo_pkg::PH_Q1:
        begin
          phase_reg    <= ilo_pkg::PH_Q2;
          op_reg       <= dec_op;
          illegal_reg  <= (dec_op == ilo_pkg::OP_NONE);
          dest_reg     <= dec_dest;
          bit_reg      <= dec_bit;
          acc_a_reg    <= acc_reg;
          mem_addr_reg <= dec_ea;
          mem_re_reg   <= (dec_op != ilo_pkg::OP_NONE);
          indexed_reg  <= dec_indexed;
        end
        ilo_pkg::PH_Q2:
          phase_reg <= ilo_pkg::PH_Q3;
        ilo_pkg::PH_Q3:
        begin
          phase_reg     <= ilo_pkg::PH_Q4;
          mem_re_reg    <= 1'b0;
          operand_reg   <= mem_rdata;
          mem_wdata_reg <= result;
          mem_we_reg    <= (op_reg != ilo_pkg::OP_NONE) && ((op_reg != ilo_pkg::OP_ADD) || dest_reg);
        end
        ilo_pkg::PH_Q4:
        begin
          phase_reg  <= ilo_pkg::PH_IDLE;
          mem_we_reg <= 1'b0;
        end
        default:
          phase_reg <= ilo_pkg::PH_IDLE;
      endcase
    end
  end

  // Outputs come straight from their flip-flops; busy is its own flop to stay glitch free.
  logic busy_reg;

  always_ff @(posedge mclk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
      busy_reg <= 1'b0;
    else
      busy_reg <= (phase_reg == ilo_pkg::PH_IDLE) ? start : (phase_reg != ilo_pkg::PH_Q4);
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign mem_addr       = mem_addr_reg;
  assign mem_re         = mem_re_reg;
  assign mem_we         = mem_we_reg;
  assign mem_wdata      = mem_wdata_reg;
  assign busy           = busy_reg;
  assign indexed_access = indexed_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer and the data path.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync2_reg);

  property p_index_addr;
    (phase_reg == ilo_pkg::PH_Q2) && ext_reg && !instr_reg[8] && (instr_reg[7:0] <= 8'h5f)
      |-> (mem_addr_reg == 12'(ptr2_reg + {4'h0, instr_reg[7:0]})) && indexed_reg;
  endproperty
  a_index_addr: assert property (p_index_addr) else $error("indexed address wrong");

  property p_forced_access;
    (phase_reg == ilo_pkg::PH_Q2) && indexed_reg |-> !instr_reg[8] && ext_reg;
  endproperty
  a_forced_access: assert property (p_forced_access) else $error("indexed with access set");

  property p_plain_addr;
    (phase_reg == ilo_pkg::PH_Q2) && !ext_reg |-> !indexed_reg && (mem_addr_reg ==
      (instr_reg[8] ? {bank_reg, instr_reg[7:0]} : (instr_reg[7] ? {4'hf, instr_reg[7:0]}
      : {4'h0, instr_reg[7:0]})));
  endproperty
  a_plain_addr: assert property (p_plain_addr) else $error("standard address wrong");

  property p_add_acc;
    (phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_ADD) && !dest_reg
      |-> !mem_we_reg && (acc_reg == 8'(acc_a_reg + operand_reg));
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add to accumulator wrong");

  property p_add_mem;
    (phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_ADD) && dest_reg
      |-> mem_we_reg && (mem_wdata_reg == 8'(acc_a_reg + operand_reg)) && (acc_reg == acc_a_reg);
  endproperty
  a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");

  property p_add_flags;
    (phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_ADD) |->
      (flags_reg[2] == (8'(acc_a_reg + operand_reg) == 8'h00))
      && (flags_reg[0] == ((9'(acc_a_reg) + 9'(operand_reg)) > 9'h0ff));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_bit_set;
    (phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_BSET)
      |-> mem_we_reg && (mem_wdata_reg == (operand_reg | (8'h01 << bit_reg)));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_set_all;
    (phase_reg == ilo_pkg::PH_Q3) && (op_reg == ilo_pkg::OP_SET_ALL_INDEXED)
      |=> mem_we_reg && (mem_wdata_reg == 8'hff) && $stable(flags_reg);
  endproperty
  a_set_all: assert property (p_set_all) else $error("set all wrong");

  property p_four_phase;
    start && (phase_reg == ilo_pkg::PH_IDLE) |=> busy_reg [*4] ##1 !busy_reg;
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("instruction not four phases");

  property p_ext_off;
    !ext_reg |-> !dec_indexed;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("indexing while disabled");

  c_add_acc: cover property ((phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_ADD) && !dest_reg);
  c_add_mem: cover property ((phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_ADD) && dest_reg);
  c_bit_set: cover property ((phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_BSET) && indexed_reg);
  c_set_all: cover property ((phase_reg == ilo_pkg::PH_Q4) && (op_reg == ilo_pkg::OP_SET_ALL_INDEXED) && indexed_reg);

endmodule

`default_nettype wire

// *** verif/tb_ilo_core.sv ***
// Self-checking testbench of the indexed literal offset executor over its APB port.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_ilo_core;
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] mem_addr;
  logic        mem_re;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        busy;
  logic        indexed_access;
  logic [7:0]  mem [4096];
  logic [31:0] rdv;
  logic        erv;
  logic        ia;
  int          nb;
  int          nwe;
  int          nre;
  int          err_total;
  int          n_tests;
  logic [7:0]  av [5] = '{8'h17, 8'h80, 8'h0f, 8'h7f, 8'hff};
  logic [7:0]  mv [5] = '{8'h20, 8'h80, 8'h01, 8'h01, 8'hff};

  ilo_core #(.ADDR_W(12)) dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy),
    .indexed_access(indexed_access));

  // Free-running core clock at 10 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Data memory stands in for the data space and counts what the executor does.
  always @(posedge mclk)
  begin
    if (busy === 1'b1) nb++;
    if (mem_re === 1'b1) nre++;
    // The index flag holds over from the last instruction, so only count it during the read.
    if (indexed_access === 1'b1 && mem_re === 1'b1) ia = 1'b1;
    if (mem_we === 1'b1)
    begin
      nwe++;
      mem[mem_addr] = mem_wdata;
    end
    mem_rdata <= mem[mem_addr];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the master waits for pready rather than assuming zero wait states.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only pready, or the watchdog if it never comes, ends this wait; the slave's latency is not assumed here.
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write that must be accepted.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK("slverr", 1'b0, erv)
  endtask

  // Starts one instruction and checks timing, strobes, indexing and the address used.
  task automatic run(input logic [15:0] ins, input logic [11:0] ea, input logic ix, input int we);
    nb = 0;
    nwe = 0;
    nre = 0;
    ia = 1'b0;
    wr(ilo_pkg::OFF_INSTR, {16'h0000, ins});
    repeat (6) @(posedge mclk);
    `CHK("busy cycles", 4, nb)
    `CHK("write strobes", we, nwe)
    `CHK("read strobes", 2, nre)
    `CHK("indexed", ix, ia)
    apb(1'b0, ilo_pkg::OFF_EADDR, 32'h0);
    `CHK("eaddr", {20'h00000, ea}, rdv)
  endtask

  // Flags expected from an 8-bit add, in STATUS bit order.
  function automatic logic [4:0] addf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
            ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [7:0]  k;
    logic [11:0] ea;
    logic [7:0]  sum;
    logic [31:0] st;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    mem_rdata = 8'h00; rst_n = 1'b0; err_total = 0; n_tests = 0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, ilo_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rdv)
    apb(1'b0, ilo_pkg::OFF_STATUS, 32'h0);
    `CHK("status reset", 32'h0, rdv)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped error", 1'b1, erv)
    // Extension off: literal access bank or bank-select addressing.
    wr(ilo_pkg::OFF_BANK, 32'h5);
    wr(ilo_pkg::OFF_PTR2, 32'ha00);
    wr(ilo_pkg::OFF_ACC, 32'h01);
    mem[12'h02c] = 8'h10;
    run(16'h262c, 12'h02c, 1'b0, 1);
    `CHK("access bank add", 8'h11, mem[12'h02c])
    run(16'h692c, 12'h52c, 1'b0, 1);
    `CHK("banked set", 8'hff, mem[12'h52c])
    // Extension on: indexed add with both destinations and all flags.
    wr(ilo_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      k = 8'(i * 17);
      ea = 12'ha00 + {4'h0, k};
      wr(ilo_pkg::OFF_ACC, {24'h0, av[i]});
      mem[ea] = mv[i];
      sum = av[i] + mv[i];
      run({6'b001001, i[0], 1'b0, k}, ea, 1'b1, i % 2);
      if (i[0]) `CHK("add to memory", sum, mem[ea])
      apb(1'b0, ilo_pkg::OFF_ACC, 32'h0);
      `CHK("acc after add", {24'h0, i[0] ? av[i] : sum}, rdv)
      apb(1'b0, ilo_pkg::OFF_STATUS, 32'h0);
      `CHK("add flags", {27'h0, addf(av[i], mv[i])}, rdv)
    end
    st = rdv;
    // Indexed bit set and set-all leave the flags alone.
    mem[12'ha0a] = 8'h55;
    run(16'h8e0a, 12'ha0a, 1'b1, 1);
    `CHK("bit set", 8'hd5, mem[12'ha0a])
    run(16'h682c, 12'ha2c, 1'b1, 1);
    `CHK("set all", 8'hff, mem[12'ha2c])
    apb(1'b0, ilo_pkg::OFF_STATUS, 32'h0);
    `CHK("flags kept", st, rdv)
    // Offset limit, access bit set, and wrap of the data space.
    run(16'h685f, 12'ha5f, 1'b1, 1);
    run(16'h6860, 12'h060, 1'b0, 1);
    run(16'h692c, 12'h52c, 1'b0, 1);
    wr(ilo_pkg::OFF_PTR2, 32'hff0);
    run(16'h6820, 12'h010, 1'b1, 1);
    // An opcode outside the supported set touches no memory and raises the illegal flag.
    nwe = 0;
    nre = 0;
    wr(ilo_pkg::OFF_INSTR, 32'h0);
    repeat (6) @(posedge mclk);
    `CHK("illegal accesses", 0, nwe + nre)
    apb(1'b0, ilo_pkg::OFF_STATUS, 32'h0);
    `CHK("illegal flag", st | (32'h1 << ilo_pkg::STAT_ILLEGAL), rdv)
    // A register write while busy is refused and changes nothing.
    wr(ilo_pkg::OFF_INSTR, 32'h6800);
    apb(1'b1, ilo_pkg::OFF_ACC, 32'h33);
    `CHK("busy write error", 1'b1, erv)
    repeat (6) @(posedge mclk);
    apb(1'b0, ilo_pkg::OFF_ACC, 32'h0);
    `CHK("acc kept", {24'h0, sum}, rdv)
    conclude();
  end

  // Watchdog against a hang anywhere in the sequence.
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    conclude();
  end
endmodule

`undef CHK
`default_nettype wire
